// >>> verilog/core_special_registers.sv
// core special registers: pc low, bank select, status, ports, apb slave
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "core_sfr_defs.svh"
module core_special_registers
   import core_sfr_pkg::*;
#(
   parameter bit LARGE  = 1'b1,
   parameter int PC_W   = 13
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   // apb slave
   input  wire logic             psel_i,
   input  wire logic             penable_i,
   input  wire logic             pwrite_i,
   input  wire logic [11:0]      paddr_i,
   input  wire logic [31:0]      pwdata_i,
   output logic      [31:0]      prdata_o,
   output logic                  pready_o,
   output logic                  pslverr_o,
   // core side
   input  wire sys_event_type    evt_i,
   input  wire alu_update_type   alu_i,
   input  wire mem_req_type      mem_req_i,
   input  wire logic             pc_step_i,
   output logic      [PC_W-1:0]  pc_o,
   output logic                  dummy_cycle_o,
   output logic      [2:0]       mem_bank_o,
   output logic                  mem_sfr_o,
   output logic      [1:0]       prog_bank_o,
   output logic      [7:0]       flags_o,
   output logic      [7:0]       port_a_out_o,
   output logic      [7:0]       port_a_oe_o,
   output logic      [7:0]       port_b_out_o,
   output logic      [7:0]       port_b_oe_o
);
   localparam int DBW = LARGE ? 3 : 2; // data bank width
   localparam int PBW = LARGE ? 2 : 1; // program bank width

   // apb decode
   logic        acc;       // access phase
   logic        wr;        // write takes effect
   logic        hit;       // mapped address
   logic [31:0] rdata;     // read mux
   assign acc = psel_i && penable_i;
   assign wr  = acc && pwrite_i;

   // register state
   logic [PC_W-1:0]  pc_q;        // program counter
   pc_state_type     pc_state_q;  // dummy-cycle sequencer
   logic [DBW-1:0]   dbank_q;     // data bank field
   logic [PBW-1:0]   pbank_q;     // program bank field
   logic [5:0]       status_q;    // status bits 5:0
   logic [7:0]       bank_rd;     // bank register read view
   logic [7:0]       a_data, a_dir, a_oe, b_data, b_dir, b_oe;
   logic [DBW-1:0]   map_bank;
   logic             map_sfr;
   logic             bop;         // single bit operation write

   // pc: full step, or low byte replaced on write
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_q <= '0;
      end else if (wr && paddr_i == `ADDR_PC_LOW) begin
         pc_q <= {pc_q[PC_W-1:8], pwdata_i[7:0]}; // R1
      end else if (pc_step_i && pc_state_q == PC_RUN) begin
         pc_q <= pc_q + 1'b1;
      end
   end

   // dummy cycle after a jump through pc low
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_state_q <= PC_RUN;
      end else begin
         case (pc_state_q)
            PC_RUN: begin
               if (wr && paddr_i == `ADDR_PC_LOW) begin
                  pc_state_q <= PC_DUMMY; // R2
               end
            end
            PC_DUMMY: begin
               pc_state_q <= PC_RUN; // one cycle only
            end
            default: begin
               pc_state_q <= PC_RUN;
            end
         endcase
      end
   end

   // bank select; idle watchdog reset keeps it
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dbank_q <= '0; // R7
         pbank_q <= '0; // R8 R9
      end else if (evt_i.power_up || (evt_i.wdt_reset && !evt_i.in_idle)) begin
         dbank_q <= '0; // R7
         pbank_q <= '0;
      end else if (evt_i.wdt_reset) begin
         dbank_q <= dbank_q; // R7
      end else if (wr && paddr_i == `ADDR_BANK_SEL) begin
         dbank_q <= pwdata_i[`BS_DATA_LSB +: DBW]; // R8 R9 R10
         pbank_q <= pwdata_i[`BS_PROG_LSB +: PBW]; // R10
      end
   end

   // only implemented bits show
   always_comb begin
      bank_rd = '0; // R10
      bank_rd[`BS_DATA_LSB +: DBW] = dbank_q;
      bank_rd[`BS_PROG_LSB +: PBW] = pbank_q;
   end

   // system flags: set wins over clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_q[`ST_WDT_BIT]  <= 1'b0;
         status_q[`ST_HALT_BIT] <= 1'b0;
      end else begin
         if (evt_i.watchdog_timeout) begin
            status_q[`ST_WDT_BIT] <= 1'b1; // R12
         end else if (evt_i.power_up || evt_i.clear_watchdog_instr || evt_i.halt_instr) begin
            status_q[`ST_WDT_BIT] <= 1'b0; // R12
         end
         if (evt_i.halt_instr) begin
            status_q[`ST_HALT_BIT] <= 1'b1; // R13
         end else if (evt_i.power_up || evt_i.clear_watchdog_instr) begin
            status_q[`ST_HALT_BIT] <= 1'b0; // R13
         end
      end
   end

   // arithmetic flags: alu result, or software write of bits 3:0
   logic [8:0] sum9;   // full result with carry
   logic [4:0] sum5;   // low nibble result
   logic [7:0] sum7;   // carry into msb
   logic [7:0] bop_b;  // subtract uses inverted operand
   always_comb begin
      bop_b = alu_i.sub ? ~alu_i.b : alu_i.b;
      sum9  = {1'b0, alu_i.a} + {1'b0, bop_b} + {8'h00, alu_i.sub};
      sum5  = {1'b0, alu_i.a[3:0]} + {1'b0, bop_b[3:0]} + {4'h0, alu_i.sub};
      sum7  = {1'b0, alu_i.a[6:0]} + {1'b0, bop_b[6:0]} + {7'h00, alu_i.sub};
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         status_q[3:0] <= '0;
      end else if (wr && paddr_i == `ADDR_FLAGS) begin
         status_q[3:0] <= 4'(pwdata_i[7:0] & `ST_ARITH_MASK); // R11 R18
      end else if (alu_i.valid) begin
         status_q[`ST_Z_BIT] <= (alu_i.result == 8'h00); // R15
         if (alu_i.rotate) begin
            status_q[`ST_C_BIT] <= alu_i.rot_carry; // R17
         end else if (!alu_i.logic_op) begin
            status_q[`ST_OV_BIT] <= sum7[7] ^ sum9[8]; // R14
            status_q[`ST_AC_BIT] <= sum5[4]; // R16
            status_q[`ST_C_BIT]  <= sum9[8]; // R17
         end
      end
   end

   // single-bit operation decode
   assign bop = wr && paddr_i == `ADDR_BIT_OP;

   // the two ports
   port_dir_bits #(.WIDTH(8)) u_port_a (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .wr_data_i (wr && paddr_i == `ADDR_PORT_A_DATA),
      .wr_dir_i  (wr && paddr_i == `ADDR_PORT_A_DIR),
      .wdata_i   (pwdata_i[7:0]),
      .bit_op_i  (bop && !pwdata_i[`BOP_PORTB_BIT]),
      .bit_dir_i (pwdata_i[`BOP_DIR_BIT]),
      .bit_set_i (pwdata_i[`BOP_SET_BIT]),
      .bit_idx_i (pwdata_i[2:0]),
      .data_o    (a_data),
      .dir_o     (a_dir),
      .oe_o      (a_oe)
   );
   port_dir_bits #(.WIDTH(8)) u_port_b (
      .clk_i     (clk_i),
      .nrst_i    (nrst_i),
      .wr_data_i (wr && paddr_i == `ADDR_PORT_B_DATA),
      .wr_dir_i  (wr && paddr_i == `ADDR_PORT_B_DIR),
      .wdata_i   (pwdata_i[7:0]),
      .bit_op_i  (bop && pwdata_i[`BOP_PORTB_BIT]),
      .bit_dir_i (pwdata_i[`BOP_DIR_BIT]),
      .bit_set_i (pwdata_i[`BOP_SET_BIT]),
      .bit_idx_i (pwdata_i[2:0]),
      .data_o    (b_data),
      .dir_o     (b_dir),
      .oe_o      (b_oe)
   );

   // bank mapping
   data_bank_map #(.DBW(DBW)) u_map (
      .data_bank_i (dbank_q),
      .req_i       (mem_req_i),
      .bank_o      (map_bank),
      .sfr_o       (map_sfr)
   );

   // read mux; bits 7:6 of status read zero
   always_comb begin
      hit   = 1'b1;
      rdata = '0;
      case (paddr_i)
         `ADDR_PC_LOW:      rdata = {24'h000000, pc_q[7:0]};
         `ADDR_BANK_SEL:    rdata = {24'h000000, bank_rd};
         `ADDR_FLAGS:       rdata = {26'h0000000, status_q}; // R18
         `ADDR_PORT_A_DATA: rdata = {24'h000000, a_data};
         `ADDR_PORT_A_DIR:  rdata = {24'h000000, a_dir};
         `ADDR_PORT_B_DATA: rdata = {24'h000000, b_data};
         `ADDR_PORT_B_DIR:  rdata = {24'h000000, b_dir};
         `ADDR_BIT_OP:      rdata = '0;
         `ADDR_MEM_MAP:     rdata = {28'h0000000, map_sfr, 3'(map_bank)};
         `ADDR_PC_FULL:     rdata = 32'(pc_q);
         default:           hit   = 1'b0;
      endcase
   end

   // apb answer: no wait states, pready registered
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pready_o  <= 1'b0;
         prdata_o  <= '0;
         pslverr_o <= 1'b0;
      end else if (psel_i && !penable_i) begin
         pready_o  <= 1'b1;
         prdata_o  <= pwrite_i ? 32'h00000000 : rdata;
         pslverr_o <= !hit;
      end else begin
         pready_o  <= 1'b0;
         pslverr_o <= 1'b0;
      end
   end

   // registered core outputs; status not stacked, core reads it
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pc_o          <= '0;
         dummy_cycle_o <= 1'b0;
         mem_bank_o    <= '0;
         mem_sfr_o     <= 1'b0;
         prog_bank_o   <= '0;
         flags_o       <= '0;
         port_a_out_o  <= '0;
         port_a_oe_o   <= '0;
         port_b_out_o  <= '0;
         port_b_oe_o   <= '0;
      end else begin
         pc_o          <= pc_q;
         dummy_cycle_o <= (pc_state_q == PC_DUMMY); // R2
         mem_bank_o    <= 3'(map_bank);
         mem_sfr_o     <= map_sfr;
         prog_bank_o   <= 2'(pbank_q);
         flags_o       <= {2'b00, status_q}; // R19
         port_a_out_o  <= a_data;
         port_a_oe_o   <= a_oe;
         port_b_out_o  <= b_data;
         port_b_oe_o   <= b_oe;
      end
   end
endmodule

// >>> verilog/core_sfr_defs.svh
// constants for the core special-function register block
// Notes on behaviour
// (R1) pc low write replaces low byte only
// (R2) pc low write inserts one dummy cycle
// (R3) direct data accesses always hit bank zero
// (R4) first pointer window always reaches bank zero
// (R5) second pointer window uses data bank field
// (R6) special registers decode the same in every bank
// (R7) resets zero bank, except idle watchdog reset
// (R8) small variant: prog bit5, data bits1:0
// (R9) large variant: prog bits6:5, data bits2:0
// (R10) unimplemented bank bits read zero, ignore writes
// (R11) status writes change arithmetic flags only
// (R12) watchdog flag: clear power/clrwdt/halt, set timeout
// (R13) halt flag: clear power/clrwdt, set halt
// (R14) overflow flag is carry-in xor carry-out of msb
// (R15) null flag set when result is zero
// (R16) half flag from low-nibble carry/no-borrow
// (R17) carry from add carry/no-borrow, rotates too
// (R18) status bits 7:6 read zero, 5:4 read-only
// (R19) status never stacked on call or interrupt
// (R20) direction bit one is input, zero output
// (R21) port bits settable singly, direction changeable anytime
`ifndef CORE_SFR_DEFS_SVH
`define CORE_SFR_DEFS_SVH
// apb byte addresses
`define ADDR_PC_LOW      12'h000
`define ADDR_BANK_SEL    12'h004
`define ADDR_FLAGS       12'h008
`define ADDR_PORT_A_DATA 12'h00c
`define ADDR_PORT_A_DIR  12'h010
`define ADDR_PORT_B_DATA 12'h014
`define ADDR_PORT_B_DIR  12'h018
`define ADDR_BIT_OP      12'h01c
`define ADDR_MEM_MAP     12'h020
`define ADDR_PC_FULL     12'h024
// special-register area below this data address
`define SFR_LIMIT        8'h80
// bank select fields
`define BS_PROG_LSB      5
`define BS_DATA_LSB      0
// status fields
`define ST_WDT_BIT       5
`define ST_HALT_BIT      4
`define ST_OV_BIT        3
`define ST_Z_BIT         2
`define ST_AC_BIT        1
`define ST_C_BIT         0
`define ST_ARITH_MASK    8'h0f
// bit operation word: [9] target dir, [8] port b, [4] set, [2:0] index
`define BOP_DIR_BIT      9
`define BOP_PORTB_BIT    8
`define BOP_SET_BIT      4
// direction reset: all inputs
`define DIR_RESET        8'hff
`define DUMMY_CYCLES     2'h1
`endif

// >>> verilog/core_sfr_pkg.sv
// types for the core special-function register block
package core_sfr_pkg;
   // system and instruction event strobes
   typedef struct packed {
      logic power_up;
      logic clear_watchdog_instr;
      logic halt_instr;
      logic watchdog_timeout;
      logic wdt_reset;
      logic in_idle;
   } sys_event_type;
   // alu result for flag update
   typedef struct packed {
      logic       valid;
      logic [7:0] a;
      logic [7:0] b;
      logic       sub;
      logic       logic_op;
      logic [7:0] result;
      logic       rotate;
      logic       rot_carry;
   } alu_update_type;
   // data memory access request
   typedef struct packed {
      logic       valid;
      logic       indirect;
      logic       second_ptr;
      logic [7:0] addr;
   } mem_req_type;
   typedef enum logic [1:0] {PC_RUN, PC_DUMMY} pc_state_type;
endpackage

// >>> verilog/port_dir_bits.sv
// one i/o port: data and direction with single-bit operations
`timescale 1ns/100ps
`include "core_sfr_defs.svh"
module port_dir_bits
   import core_sfr_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             nrst_i,
   input  wire logic             wr_data_i,
   input  wire logic             wr_dir_i,
   input  wire logic [WIDTH-1:0] wdata_i,
   input  wire logic             bit_op_i,
   input  wire logic             bit_dir_i,
   input  wire logic             bit_set_i,
   input  wire logic [2:0]       bit_idx_i,
   output logic      [WIDTH-1:0] data_o,
   output logic      [WIDTH-1:0] dir_o,
   output logic      [WIDTH-1:0] oe_o
);
   // output latch
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         data_o <= '0;
      end else if (wr_data_i) begin
         data_o <= wdata_i;
      end else if (bit_op_i && !bit_dir_i) begin
         data_o[bit_idx_i] <= bit_set_i; // R21
      end
   end
   // direction latch, changeable at any time
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         dir_o <= `DIR_RESET;
      end else if (wr_dir_i) begin
         dir_o <= wdata_i; // R21
      end else if (bit_op_i && bit_dir_i) begin
         dir_o[bit_idx_i] <= bit_set_i; // R21
      end
   end
   // one is input, zero drives
   assign oe_o = ~dir_o; // R20
endmodule

// >>> verilog/data_bank_map.sv
// data memory bank mapping for direct and indirect accesses
`timescale 1ns/100ps
`include "core_sfr_defs.svh"
module data_bank_map
   import core_sfr_pkg::*;
#(
   parameter int DBW = 3
) (
   input  wire logic [DBW-1:0] data_bank_i,
   input  wire mem_req_type    req_i,
   output logic      [DBW-1:0] bank_o,
   output logic                sfr_o
);
   // special area ignores bank entirely
   assign sfr_o = req_i.valid && (req_i.addr < `SFR_LIMIT); // R6
   // only second pointer window follows the bank field
   always_comb begin
      if (req_i.indirect && req_i.second_ptr && !sfr_o) begin
         bank_o = data_bank_i; // R5
      end else begin
         bank_o = '0; // R3 R4
      end
   end
endmodule

// >>> verif/core_sfr_assertions.sv
// assertion checker for the core special registers, bound to its ports
`timescale 1ns/100ps
`include "core_sfr_defs.svh"
module core_sfr_assertions
   import core_sfr_pkg::*;
#(
   parameter bit LARGE = 1'b1,
   parameter int PC_W  = 13
) (
   input wire logic            clk_i,
   input wire logic            nrst_i,
   input wire logic            psel_i,
   input wire logic            penable_i,
   input wire logic            pwrite_i,
   input wire logic [11:0]     paddr_i,
   input wire logic [31:0]     pwdata_i,
   input wire sys_event_type   evt_i,
   input wire alu_update_type  alu_i,
   input wire mem_req_type     mem_req_i,
   input wire logic [PC_W-1:0] pc_o,
   input wire logic            dummy_cycle_o,
   input wire logic [2:0]      mem_bank_o,
   input wire logic            mem_sfr_o,
   input wire logic [7:0]      flags_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   logic [7:0] bx;    // second operand as the adder sees it
   logic [8:0] sum;   // full adder result with carry out
   logic [4:0] nib;   // low nibble sum with its carry
   logic       ovc;   // signed wrap expected
   logic       zres;  // result is zero
   logic       wst;   // status write access
   logic       pcw;   // pc low write access
   logic       arith; // arithmetic flag update
   logic [3:0] wlo;   // written arithmetic bits
   logic [7:0] wpc;   // written pc low byte
   assign bx    = alu_i.sub ? ~alu_i.b : alu_i.b;
   assign sum   = {1'b0, alu_i.a} + {1'b0, bx} + {8'h00, alu_i.sub};
   assign nib   = {1'b0, alu_i.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, alu_i.sub};
   assign ovc   = alu_i.a[7] ^ bx[7] ^ sum[7] ^ sum[8];
   assign zres  = (alu_i.result == 8'h00);
   assign wst   = psel_i & penable_i & pwrite_i & (paddr_i == `ADDR_FLAGS);
   assign pcw   = psel_i & penable_i & pwrite_i & (paddr_i == `ADDR_PC_LOW);
   assign arith = alu_i.valid & ~alu_i.logic_op & ~alu_i.rotate & ~wst;
   assign wlo   = pwdata_i[3:0];
   assign wpc   = pwdata_i[7:0];
   AST_PC_LOW: assert property (pcw |-> ##2 pc_o[7:0] == $past(wpc, 2)) else $error("pc low not loaded");
   AST_DUMMY: assert property (pcw |-> ##[2:3] dummy_cycle_o) else $error("no dummy cycle");
   AST_DIRECT: assert property (mem_req_i.valid && !mem_req_i.indirect |=> mem_bank_o == 3'h0) else $error("direct bank");
   AST_PTR0: assert property (mem_req_i.valid && mem_req_i.indirect && !mem_req_i.second_ptr
      |=> mem_bank_o == 3'h0) else $error("first pointer bank");
   AST_SFR: assert property (mem_req_i.valid && mem_req_i.addr < `SFR_LIMIT
      |=> mem_sfr_o && mem_bank_o == 3'h0) else $error("special area decode");
   AST_FLAG_WRITE: assert property (wst |-> ##2 flags_o[3:0] == $past(wlo, 2)) else $error("status write lost");
   AST_FLAG_KEEP: assert property (wst && evt_i == '0 |-> ##2 $stable(flags_o[5:4])) else $error("status write hit flags");
   AST_TO_SET: assert property (evt_i.watchdog_timeout |-> ##2 flags_o[5]) else $error("timeout flag not set");
   AST_HALT: assert property (evt_i.halt_instr && !evt_i.watchdog_timeout |-> ##2 flags_o[5:4] == 2'b01)
      else $error("halt flags wrong");
   AST_CLRWDT: assert property (evt_i.clear_watchdog_instr && !evt_i.halt_instr && !evt_i.watchdog_timeout
      |-> ##2 flags_o[5:4] == 2'b00) else $error("clear watchdog flags wrong");
   AST_OV: assert property (arith |-> ##2 flags_o[3] == $past(ovc, 2)) else $error("overflow flag wrong");
   AST_ZERO: assert property (alu_i.valid && !alu_i.rotate && !wst |-> ##2 flags_o[2] == $past(zres, 2))
      else $error("zero flag wrong");
   AST_CARRY: assert property (arith |-> ##2 flags_o[1:0] == $past({nib[4], sum[8]}, 2))
      else $error("carry flags wrong");
   AST_HIGH_ZERO: assert property (flags_o[7:6] == 2'b00) else $error("status high bits set");
   cover property (pcw);
   cover property (evt_i.halt_instr);
   cover property (arith);
endmodule
bind core_special_registers core_sfr_assertions #(.LARGE(LARGE), .PC_W(PC_W)) u_sfr_chk (.clk_i, .nrst_i,
   .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i, .evt_i, .alu_i, .mem_req_i, .pc_o, .dummy_cycle_o,
   .mem_bank_o, .mem_sfr_o, .flags_o);

// >>> verif/core_special_registers_tb.sv
// self-checking bench for the core special registers
`timescale 1ns/100ps
`include "core_sfr_defs.svh"
module core_special_registers_tb import core_sfr_pkg::*;;
   logic           clk_i, nrst_i, psel_i, penable_i, pwrite_i, pc_step_i;
   logic [11:0]    paddr_i;
   logic [31:0]    pwdata_i, prdata_o;
   logic           pready_o, pslverr_o, dummy_cycle_o, mem_sfr_o;
   sys_event_type  evt_i;
   alu_update_type alu_i;
   mem_req_type    mem_req_i;
   logic [12:0]    pc_o;
   logic [2:0]     mem_bank_o;
   logic [1:0]     prog_bank_o;
   logic [7:0]     flags_o, port_a_out_o, port_a_oe_o, port_b_out_o, port_b_oe_o;
   int             failures, total_checks, dummies;
   core_special_registers dut (.clk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
      .prdata_o, .pready_o, .pslverr_o, .evt_i, .alu_i, .mem_req_i, .pc_step_i, .pc_o, .dummy_cycle_o,
      .mem_bank_o, .mem_sfr_o, .prog_bank_o, .flags_o, .port_a_out_o, .port_a_oe_o, .port_b_out_o, .port_b_oe_o);
   // free running clock
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // count dummy cycle pulses
   always @(posedge clk_i) begin
      if (dummy_cycle_o === 1'b1) dummies++;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   // one apb transfer, waits for pready, checks response
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] exp,
                      input logic err);
      int n;
      n = 0;
      psel_i    <= 1'b1;
      pwrite_i  <= wr;
      paddr_i   <= a;
      pwdata_i  <= wd;
      @(posedge clk_i);
      penable_i <= 1'b1;
      @(posedge clk_i);
      while (pready_o !== 1'b1 && n < 16) begin
         n++;
         @(posedge clk_i);
      end
      chk({31'h0, pslverr_o}, {31'h0, err});
      if (!wr) chk(prdata_o, exp);
      psel_i    <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 32'h0, 1'b0);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, exp, 1'b0);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // one memory request, checks {sfr, bank}
   task automatic mem(input logic ind, input logic sec, input logic [7:0] a, input logic [3:0] exp);
      mem_req_i <= '{1'b1, ind, sec, a};
      @(posedge clk_i);
      mem_req_i <= '0;
      @(posedge clk_i);
      chk({28'h0, mem_sfr_o, mem_bank_o}, {28'h0, exp});
   endtask
   task automatic ev(input sys_event_type e);
      evt_i <= e;
      @(posedge clk_i);
      evt_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic alu(input logic [7:0] a, b, input logic sub, lop, input logic [7:0] res, input logic rot, rc);
      alu_i <= '{1'b1, a, b, sub, lop, res, rot, rc};
      @(posedge clk_i);
      alu_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic end_of_test;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // hang guard
   initial begin
      #100000;
      failures++;
      end_of_test;
   end
   initial begin
      {nrst_i, psel_i, penable_i, pwrite_i, pc_step_i} = 5'h0;
      {paddr_i, pwdata_i, evt_i, alu_i, mem_req_i} = '0;
      repeat (6) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      rd(`ADDR_BANK_SEL, 32'h0);
      rd(`ADDR_FLAGS, 32'h0);
      rd(`ADDR_PORT_A_DIR, 32'hff);
      chk({24'h0, port_a_oe_o}, 32'h0);
      apb(1'b0, 12'h040, 32'h0, 32'h0, 1'b1);
      wr(`ADDR_BANK_SEL, 32'hffff_ffff);
      rd(`ADDR_BANK_SEL, 32'h67);
      chk({30'h0, prog_bank_o}, 32'h3);
      mem(1'b0, 1'b0, 8'h90, 4'h0);
      mem(1'b1, 1'b0, 8'h90, 4'h0);
      mem(1'b1, 1'b1, 8'h90, 4'h7);
      mem(1'b1, 1'b1, 8'h10, 4'h8);
      ev(6'h03);
      rd(`ADDR_BANK_SEL, 32'h67);
      ev(6'h02);
      rd(`ADDR_BANK_SEL, 32'h0);
      wr(`ADDR_FLAGS, 32'hff);
      rd(`ADDR_FLAGS, 32'h0f);
      ev(6'h08);
      rd(`ADDR_FLAGS, 32'h1f);
      ev(6'h04);
      rd(`ADDR_FLAGS, 32'h3f);
      ev(6'h08);
      rd(`ADDR_FLAGS, 32'h1f);
      wr(`ADDR_FLAGS, 32'h00);
      rd(`ADDR_FLAGS, 32'h10);
      ev(6'h10);
      rd(`ADDR_FLAGS, 32'h00);
      alu(8'h7f, 8'h01, 1'b0, 1'b0, 8'h80, 1'b0, 1'b0);
      rd(`ADDR_FLAGS, 32'h0a);
      alu(8'h05, 8'h03, 1'b1, 1'b0, 8'h02, 1'b0, 1'b0);
      rd(`ADDR_FLAGS, 32'h03);
      alu(8'hff, 8'h01, 1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
      rd(`ADDR_FLAGS, 32'h07);
      alu(8'h00, 8'h00, 1'b0, 1'b1, 8'h55, 1'b0, 1'b0);
      rd(`ADDR_FLAGS, 32'h03);
      alu(8'h00, 8'h00, 1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
      rd(`ADDR_FLAGS, 32'h06);
      wr(`ADDR_PC_LOW, 32'hff);
      tick(4);
      pc_step_i <= 1'b1;
      tick(1);
      pc_step_i <= 1'b0;
      wr(`ADDR_PC_LOW, 32'h5a);
      tick(4);
      rd(`ADDR_PC_FULL, 32'h15a);
      chk(dummies, 32'h2);
      wr(`ADDR_PORT_A_DIR, 32'h0f);
      tick(1);
      chk({24'h0, port_a_oe_o}, 32'hf0);
      wr(`ADDR_PORT_A_DATA, 32'ha5);
      wr(`ADDR_BIT_OP, 32'h217);
      tick(1);
      chk({16'h0, port_a_out_o, port_a_oe_o}, 32'ha570);
      wr(`ADDR_PORT_B_DATA, 32'hff);
      wr(`ADDR_PORT_B_DIR, 32'h00);
      wr(`ADDR_BIT_OP, 32'h100);
      wr(`ADDR_BIT_OP, 32'h313);
      tick(1);
      chk({16'h0, port_b_out_o, port_b_oe_o}, 32'hfef7);
      end_of_test;
   end
endmodule
